// *** verilog/sdic_pkg.sv ***
// Purpose: Shared constants and types for the serial converter input control
// Assumes: 16-bit converter word, serial link on its own clock
// Notes: Reset codes and link widths live here
package sdic_pkg;
	localparam int SDIC_WORD_WIDTH = 16;
	localparam int SDIC_CHAIN_DELAY = 16;
	localparam logic [15:0] SDIC_CODE_MIN = 16'h0000;
	localparam logic [15:0] SDIC_CODE_MID = 16'h8000;
	localparam int SDIC_SYNC_STAGES = 2;

	localparam logic [3:0] SDIC_REG_CONV = 4'h0;
	localparam logic [3:0] SDIC_REG_INPUT = 4'h1;
	localparam logic [3:0] SDIC_REG_STATUS = 4'h2;
	localparam logic [3:0] SDIC_REG_CTRL = 4'h3;
	localparam logic [15:0] SDIC_READ_NONE = 16'h0000;

	localparam int SDIC_ST_REFON = 0;
	localparam int SDIC_ST_SEL = 1;
	localparam int SDIC_ST_RESET = 2;
	localparam int SDIC_ST_CS = 3;
	localparam int SDIC_CTRL_SWLOAD = 0;

	typedef struct packed {
		logic chip_select_n;
		logic data_in;
	} sdic_link_type;

	typedef struct packed {
		logic load_strobe;
		logic reset_n;
		logic reset_scale_select;
		logic internal_ref_enable_n;
	} sdic_pins_type;
endpackage

// *** verilog/sdic_sync.sv ***
// Purpose: Two-stage level synchroniser, one per bit
// Assumes: Input is asynchronous to clk
// Notes: First stage is read only by the second stage
module sdic_sync
	import sdic_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end
endmodule

// *** verilog/sdic_shifter.sv ***
// Purpose: Serial-clock side: input shift register and daisy-chain delay
// Assumes: Runs on the link clock, which may stop between frames
// Notes: Word toggle marks each completed 16-bit word for the other domain
module sdic_shifter
	import sdic_pkg::*;
#(
	parameter int WIDTH = SDIC_WORD_WIDTH
) (
	input wire logic link_clk,
	input wire logic rst,
	input wire sdic_link_type link,
	output logic [WIDTH-1:0] shift_word,
	output logic data_out,
	output logic data_out_en_n,
	output logic word_toggle
);
	logic [$clog2(WIDTH)-1:0] bit_count;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			shift_word <= '0;
		end else if (!link.chip_select_n) begin // [R1]
			shift_word <= {shift_word[WIDTH-2:0], link.data_in}; // [R2]
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			bit_count <= '0;
			word_toggle <= 1'b0;
		end else if (!link.chip_select_n) begin
			bit_count <= bit_count + 1'b1;
			if (bit_count == ($clog2(WIDTH))'(WIDTH - 1)) begin
				word_toggle <= ~word_toggle;
			end
		end
	end

	always_comb begin
		data_out = shift_word[WIDTH-1]; // [R3]
		data_out_en_n = link.chip_select_n; // [R1]
	end
endmodule

// *** verilog/sdic_top.sv ***
// Purpose: Digital control front end of a 16-bit serial-input converter
// Assumes: mclk 100 MHz; serial link clock on its own port; pins async
// Notes: Registers reached over a plain strobe port
//
// Operation
// (R1) Chip select is active low and the link shifts only while it is low.
// (R2) Serial data is captured into the input shift register on every rising serial clock while chip select is low.
// (R3) The serial data output repeats the input stream 16 serial clocks later.
// (R4) A rising edge of the load strobe copies the input register into the converter register.
// (R5) While reset is low the converter register is forced to the selected reset code.
// (R6) Reset select high picks mid-scale, low picks min-scale.
// (R7) Reference enable low turns the internal reference on, high leaves it off.
// (R8) Min-scale is 0000 hex and mid-scale is 8000 hex, applied at once.
// (R9) The host sends each word most significant bit first.
// (R10) The host shifts 16 bits per frame, then pulses the load strobe once.
//
// Strobed register access and the address map are this design's own decisions.
module sdic_top
	import sdic_pkg::*;
#(
	parameter int WIDTH = SDIC_WORD_WIDTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire sdic_link_type link,
	input wire sdic_pins_type pins,
	output logic data_out,
	output logic data_out_en_n,
	output logic internal_ref_on,
	output logic [WIDTH-1:0] conv_code,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata
);
	logic [WIDTH-1:0] shift_word;
	logic word_toggle;
	logic [WIDTH-1:0] input_word;
	logic [3:0] pins_sync;
	logic [1:0] link_sync;
	logic [2:0] word_seen;
	logic load_prev;
	logic load_rise;
	logic sw_load;
	logic next_sw_load;
	logic [WIDTH-1:0] next_conv_code;
	logic [WIDTH-1:0] reset_code;
	logic [SDIC_SYNC_STAGES:0] ready_pipe;

	sdic_shifter #(
		.WIDTH(WIDTH)
	) u_shifter (
		.link_clk(link_clk),
		.rst(sys_rst),
		.link(link),
		.shift_word(shift_word),
		.data_out(data_out),
		.data_out_en_n(data_out_en_n),
		.word_toggle(word_toggle)
	);

	sdic_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.clk(mclk),
		.rst(sys_rst),
		.async_in(pins),
		.sync_out(pins_sync)
	);

	sdic_sync #(
		.WIDTH(2)
	) u_link_sync (
		.clk(mclk),
		.rst(sys_rst),
		.async_in({word_toggle, link.chip_select_n}),
		.sync_out(link_sync)
	);

	// Word toggle edge: shift_word is stable once the frame stopped shifting
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			word_seen <= '0;
			input_word <= '0;
		end else begin
			word_seen <= {word_seen[1:0], link_sync[1]};
			if (word_seen[2] != word_seen[1]) begin
				input_word <= shift_word; // [R2]
			end
		end
	end

	// Load strobe edge detect on synchronised pin
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			load_prev <= 1'b0;
		end else begin
			load_prev <= pins_sync[3];
		end
	end

	// Edge detection waits until the synchronisers hold real pin levels
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_pipe <= '0;
		end else begin
			ready_pipe <= {ready_pipe[SDIC_SYNC_STAGES-1:0], 1'b1};
		end
	end

	assign load_rise = pins_sync[3] && !load_prev && ready_pipe[SDIC_SYNC_STAGES]; // [R4]

	always_comb begin
		reset_code = pins_sync[1] ? SDIC_CODE_MID : SDIC_CODE_MIN; // [R6] [R8]
		next_conv_code = conv_code;
		if (!pins_sync[2]) begin
			next_conv_code = reset_code; // [R5]
		end else if (load_rise || sw_load) begin
			next_conv_code = input_word; // [R4]
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_code <= SDIC_CODE_MIN;
		end else begin
			conv_code <= next_conv_code;
		end
	end

	always_comb begin
		internal_ref_on = !pins_sync[0]; // [R7]
	end

	always_comb begin
		next_sw_load = reg_write && reg_addr == SDIC_REG_CTRL && reg_wdata[SDIC_CTRL_SWLOAD];
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sw_load <= 1'b0;
		end else begin
			sw_load <= next_sw_load;
		end
	end

	// Register read port
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= SDIC_READ_NONE;
		end else if (reg_read) begin
			case (reg_addr)
				SDIC_REG_CONV: reg_rdata <= 16'(conv_code);
				SDIC_REG_INPUT: reg_rdata <= 16'(input_word);
				SDIC_REG_STATUS: begin
					reg_rdata <= SDIC_READ_NONE;
					reg_rdata[SDIC_ST_REFON] <= internal_ref_on;
					reg_rdata[SDIC_ST_SEL] <= pins_sync[1];
					reg_rdata[SDIC_ST_RESET] <= !pins_sync[2];
					reg_rdata[SDIC_ST_CS] <= !link_sync[0]; // [R1]
				end
				default: reg_rdata <= SDIC_READ_NONE;
			endcase
		end else begin
			reg_rdata <= SDIC_READ_NONE;
		end
	end

	// Assertions
	a_reset_forces_code: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		!pins_sync[2] |=> conv_code == $past(reset_code))
		else $error("converter code not forced during reset");

	a_mid_scale_pick: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
		(!pins_sync[2] && pins_sync[1]) |=> conv_code == SDIC_CODE_MID)
		else $error("mid-scale not applied");

	a_min_scale_pick: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
		(!pins_sync[2] && !pins_sync[1]) |=> conv_code == SDIC_CODE_MIN)
		else $error("min-scale not applied");

	sequence load_edge_seq;
		ready_pipe[SDIC_SYNC_STAGES] ##0 !load_prev ##0 pins_sync[3] ##0 pins_sync[2];
	endsequence

	a_load_copies_word: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		load_edge_seq |=> conv_code == $past(input_word))
		else $error("load edge did not copy input word");

	a_code_holds: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		(pins_sync[2] && !load_rise && !sw_load) |=> $stable(conv_code))
		else $error("converter code changed without load");

	a_ref_enable_low: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
		ready_pipe[SDIC_SYNC_STAGES-1] |-> internal_ref_on == !$past(pins.internal_ref_enable_n, 2))
		else $error("reference state wrong");

	a_chain_out_bit: assert property (@(posedge link_clk) disable iff (sys_rst) // [R3]
		!link.chip_select_n |=> data_out == $past(shift_word[WIDTH-2]))
		else $error("daisy-chain output wrong");

	a_shift_capture: assert property (@(posedge link_clk) disable iff (sys_rst) // [R2]
		!link.chip_select_n |=> shift_word[0] == $past(link.data_in))
		else $error("serial bit not captured");

	a_idle_hold: assert property (@(posedge link_clk) disable iff (sys_rst) // [R1]
		link.chip_select_n |=> $stable(shift_word))
		else $error("shifted while not selected");

	a_out_release: assert property (@(posedge link_clk) disable iff (sys_rst) // [R1]
		link.chip_select_n |-> data_out_en_n)
		else $error("data output driven while not selected");

	a_pin_sync_lag: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		ready_pipe[SDIC_SYNC_STAGES-1] |-> pins_sync == $past(pins, 2))
		else $error("pin synchroniser lag wrong");

	a_load_masked: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		!ready_pipe[SDIC_SYNC_STAGES] |-> !load_rise)
		else $error("load edge seen before synchronisers settled");

	a_sw_load_copy: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		(sw_load && pins_sync[2]) |=> conv_code == $past(input_word))
		else $error("software load did not copy input word");

	a_reset_over_load: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		(!pins_sync[2] && (load_rise || sw_load)) |=> conv_code == $past(reset_code))
		else $error("load overrode reset");

	sequence reset_fall_seq;
		pins_sync[2] ##1 !pins_sync[2];
	endsequence

	a_reset_at_once: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
		reset_fall_seq |=> conv_code == $past(reset_code))
		else $error("reset code not applied at once");

	a_reset_sel_switch: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
		(!pins_sync[2] && $changed(pins_sync[1])) |=> conv_code == $past(reset_code))
		else $error("reset select change not followed");

	a_code_legal_reset: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
		!pins_sync[2] |=> (conv_code == SDIC_CODE_MID || conv_code == SDIC_CODE_MIN))
		else $error("reset code not min or mid scale");

	sequence word_edge_seq;
		word_seen[2] != word_seen[1];
	endsequence

	a_word_handoff: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
		word_edge_seq |=> input_word == $past(shift_word))
		else $error("completed word not handed over");

	a_input_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
		(word_seen[2] == word_seen[1]) |=> $stable(input_word))
		else $error("input word changed without a new word");

	a_sw_load_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		sw_load |-> $past(reg_write))
		else $error("software load without write");

	a_write_other_ignored: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		(reg_write && reg_addr != SDIC_REG_CTRL) |=> !sw_load)
		else $error("write to other register started a load");

	a_load_rise_once: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		load_rise |=> !load_rise)
		else $error("load edge seen twice");

	a_rdata_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		!reg_read |=> reg_rdata == SDIC_READ_NONE)
		else $error("read data not cleared");

	a_rdata_unmapped: assert property (@(posedge mclk) disable iff (sys_rst)
		(reg_read && reg_addr > SDIC_REG_CTRL) |=> reg_rdata == SDIC_READ_NONE)
		else $error("unmapped read not zero");

	a_rdata_conv: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		(reg_read && reg_addr == SDIC_REG_CONV) |=> reg_rdata == 16'($past(conv_code)))
		else $error("converter code read wrong");

	a_rdata_input: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
		(reg_read && reg_addr == SDIC_REG_INPUT) |=> reg_rdata == 16'($past(input_word)))
		else $error("input word read wrong");

	sequence status_read_seq;
		reg_read && reg_addr == SDIC_REG_STATUS;
	endsequence

	a_status_cs: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
		status_read_seq |=> reg_rdata[SDIC_ST_CS] == !$past(link_sync[0]))
		else $error("status select bit wrong");

	a_status_ref: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
		status_read_seq |=> reg_rdata[SDIC_ST_REFON] == $past(internal_ref_on))
		else $error("status reference bit wrong");

	a_status_sel: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
		status_read_seq |=> reg_rdata[SDIC_ST_SEL] == $past(pins_sync[1]))
		else $error("status scale select bit wrong");

	a_status_reset: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		status_read_seq |=> reg_rdata[SDIC_ST_RESET] == !$past(pins_sync[2]))
		else $error("status reset bit wrong");
endmodule

// *** verification/sdic_host_model.sv ***
// Purpose: Host side of the serial link, shifts words into the converter
// Assumes: Link clock 48 ns, stands still outside frames
// Notes: Captures the chain output into back before each rising edge
module sdic_host_model
	import sdic_pkg::*;
(
	output logic link_clk,
	output sdic_link_type link,
	input wire logic data_out,
	input wire logic data_out_en_n,
	output logic [15:0] back
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		link_clk = 1'h0;
		link = '{chip_select_n: 1'h1, data_in: 1'h0};
		back = 16'h0000;
	end
	// With sel_n high the edges are strays and must be ignored
	task automatic send(input logic [15:0] word, input logic sel_n);
		link.chip_select_n = sel_n;
		#30;
		for (int i = 15; i >= 0; i--) begin
			link.data_in = word[i];
			#24;
			back = {back[14:0], data_out};
			link_clk = 1'h1;
			#24;
			link_clk = 1'h0;
		end
		#20;
		link.chip_select_n = 1'h1;
		// Released line shows the inverse of its last value
		link.data_in = ~link.data_in;
	endtask
endmodule

// *** verification/tb_sdic_top.sv ***
// Purpose: Self-checking bench for the converter input control
// Assumes: mclk 100 MHz, link clock from the host model
// Notes: Pins change at mclk edges and settle for six cycles
module tb_sdic_top
	import sdic_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, sys_rst, link_clk, data_out, data_out_en_n, internal_ref_on, reg_write, reg_read;
	sdic_link_type link;
	sdic_pins_type pins;
	logic [15:0] conv_code, reg_wdata, reg_rdata, back;
	logic [3:0] reg_addr;
	int error_cnt, checks_done;
	sdic_top sdic_top_i(.mclk, .sys_rst, .link_clk, .link, .pins, .data_out, .data_out_en_n,
		.internal_ref_on, .conv_code, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
	sdic_host_model sdic_host_model_i(.link_clk, .link, .data_out, .data_out_en_n, .back);
	always #5 mclk = ~mclk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge mclk);
		reg_write <= 1'h0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge mclk);
		reg_read <= 1'h0;
		@(negedge mclk);
		check(reg_rdata, exp);
	endtask
	task automatic pin(input sdic_pins_type p);
		@(posedge mclk);
		pins <= p;
		cyc(6);
		@(negedge mclk);
	endtask
	initial begin
		#200000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		mclk = 1'h0;
		sys_rst = 1'h1;
		pins = '{1'h0, 1'h1, 1'h0, 1'h1};
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'h0;
		reg_read = 1'h0;
		error_cnt = 0;
		checks_done = 0;
		cyc(2);
		sys_rst <= 1'h0;
		@(negedge mclk);
		check(conv_code, SDIC_CODE_MIN);
		check(16'(data_out_en_n), 16'h0001);
		fork
			sdic_host_model_i.send(16'hA5C3, 1'h0);
			begin
				#200;
				check(16'(data_out_en_n), 16'h0000);
				reg_rd(SDIC_REG_STATUS, 16'h0008);
			end
		join
		cyc(10);
		reg_rd(SDIC_REG_INPUT, 16'hA5C3);
		check(conv_code, SDIC_CODE_MIN);
		pin('{1'h1, 1'h1, 1'h0, 1'h1});
		check(conv_code, 16'hA5C3);
		pin('{1'h0, 1'h1, 1'h0, 1'h1});
		reg_rd(SDIC_REG_CONV, 16'hA5C3);
		// Stray edges with chip select high, then a real frame
		sdic_host_model_i.send(16'hFFFF, 1'h1);
		sdic_host_model_i.send(16'h1234, 1'h0);
		check(back, 16'hA5C3);
		cyc(10);
		reg_rd(SDIC_REG_INPUT, 16'h1234);
		reg_wr(SDIC_REG_CTRL, 16'h0001);
		cyc(3);
		@(negedge mclk);
		check(conv_code, 16'h1234);
		reg_rd(4'h9, SDIC_READ_NONE);
		pin('{1'h0, 1'h0, 1'h1, 1'h1});
		check(conv_code, SDIC_CODE_MID);
		reg_rd(SDIC_REG_STATUS, 16'h0006);
		pin('{1'h1, 1'h0, 1'h1, 1'h1});
		check(conv_code, SDIC_CODE_MID);
		pin('{1'h0, 1'h0, 1'h0, 1'h1});
		check(conv_code, SDIC_CODE_MIN);
		pin('{1'h0, 1'h1, 1'h0, 1'h1});
		pin('{1'h1, 1'h1, 1'h0, 1'h1});
		check(conv_code, 16'h1234);
		pin('{1'h1, 1'h1, 1'h0, 1'h0});
		check(16'(internal_ref_on), 16'h0001);
		reg_rd(SDIC_REG_STATUS, 16'h0001);
		pin('{1'h1, 1'h1, 1'h0, 1'h1});
		check(16'(internal_ref_on), 16'h0000);
		@(posedge mclk);
		sys_rst <= 1'h1;
		@(negedge mclk);
		check(conv_code, SDIC_CODE_MIN);
		cyc(2);
		sys_rst <= 1'h0;
		cyc(6);
		@(negedge mclk);
		check(conv_code, SDIC_CODE_MIN);
		wrap_up;
	end
endmodule
